// *** rtl/psr_cfg.svh ***
// Operation
// - pin/floppy setup register is accessed only in config state with index 03h.
// - reset loads pin/floppy setup register with 70h.
// - bit 1 selects normal (0) or enhanced floppy mode 2 (1).
// - bit 4 low drives programmed density value; high forces second density output high.
// - bits 6,5 choose floppy interface: 11 AT, 10 reserved, 01 second, 00 third.
// - multiplexed decode/clock-run pin floats after reset until a function is chosen.
// - extended setup register is accessed only in config state with index 04h.
// - reset clears extended setup register to 00h.
// - bits 1:0 pick parallel mode: SPP, EPP+SPP, ECP, ECP+EPP.
// - bits 3:2 pick parallel-port floppy option: normal, one, two, reserved.
// - bit 4 sets serial port 1 divisor: 13 normal, 12 with MIDI.
// - bit 5 sets serial port 2 divisor: 13 normal, 12 with MIDI.
// - bit 6 selects EPP revision: 0 is 1.9, 1 is 1.7.
// - printer mode high forces plain printer mode over the extended encoding.
// - floppy outputs tri-stated float the second density output regardless of force bit.
`ifndef PSR_CFG_SVH
`define PSR_CFG_SVH

// register indices as seen through the configuration index register
`define PSR_IDX_PIN_FLOPPY 8'h03
`define PSR_IDX_EXT_SETUP 8'h04

// reset values
`define PSR_RST_PIN_FLOPPY 8'h70
`define PSR_RST_EXT_SETUP 8'h00

// writable-bit masks, reserved bits clear
`define PSR_MASK_PIN_FLOPPY 8'hf7
`define PSR_MASK_EXT_SETUP 8'h7f

// pin and floppy setup register fields
`define PSR_B_SHARED_FN 0
`define PSR_B_ENH_FLOPPY 1
`define PSR_B_MUX_LO 2
`define PSR_B_DENS_FORCE 4
`define PSR_B_REC_MODE 5
`define PSR_B_IF_IDENT 6
`define PSR_B_MUX_HI 7

// extended setup register fields
`define PSR_B_PAR_MODE_LO 0
`define PSR_B_PAR_MODE_HI 1
`define PSR_B_PPFD_LO 2
`define PSR_B_PPFD_HI 3
`define PSR_B_MIDI1 4
`define PSR_B_MIDI2 5
`define PSR_B_EPP_TYPE 6

// serial clock divisors, stored as terminal count (divisor - 1)
`define PSR_DIV_NORMAL_TC 4'hc
`define PSR_DIV_MIDI_TC 4'hb

`endif

// *** rtl/psr_clkdiv.sv ***
`timescale 1ns/10ps
`include "psr_cfg.svh"

module psr_clkdiv (
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic ce, // clock enable
  input wire logic midi, // 1: divide by 12, 0: divide by 13
  output logic tick // one-cycle baud clock enable
);

  logic [3:0] count;

  // a divisor change takes effect at the next reload, so no short period appears
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      count <= `PSR_DIV_NORMAL_TC;
      tick <= 1'b0;
    end
    else if (ce)
    begin
      tick <= (count == 4'h0);
      if (count == 4'h0)
        count <= midi ? `PSR_DIV_MIDI_TC : `PSR_DIV_NORMAL_TC;
      else
        count <= count - 4'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_div_reload;
    ce && (count == 4'h0) |=> (count == ($past(midi) ? 4'hb : 4'hc)) && tick;
  endproperty
  a_div_reload: assert property (p_div_reload) else $error("divider reload value wrong");

  property p_div_step;
    ce && (count != 4'h0) |=> (count == $past(count) - 4'h1) && !tick;
  endproperty
  a_div_step: assert property (p_div_step) else $error("divider did not count down");

endmodule : psr_clkdiv

// *** rtl/psr_pkg.sv ***
package psr_pkg;

  typedef enum logic [1:0] {
    PSR_FDC_THIRD = 2'h0,
    PSR_FDC_SECOND = 2'h1,
    PSR_FDC_RSVD = 2'h2,
    PSR_FDC_AT = 2'h3
  } psr_fdc_mode_t;

  typedef enum logic [2:0] {
    PSR_PAR_SPP = 3'h0,
    PSR_PAR_EPP_SPP = 3'h1,
    PSR_PAR_ECP = 3'h2,
    PSR_PAR_ECP_EPP = 3'h3,
    PSR_PAR_PRINTER = 3'h4
  } psr_par_mode_t;

  typedef enum logic [1:0] {
    PSR_MUX_OFF = 2'h0,
    PSR_MUX_ADDR = 2'h2,
    PSR_MUX_CLKRUN = 2'h3
  } psr_mux_fn_t;

endpackage : psr_pkg

// *** rtl/psr_top.sv ***
`timescale 1ns/10ps
`include "psr_cfg.svh"

module psr_top (
  input wire logic clk, // system clock, 100 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic ce, // clock enable, freezes all state when low
  input wire logic cfg_state, // controller is in configuration state
  input wire logic [7:0] config_index_register, // current configuration index
  input wire logic wr_en, // write strobe for the indexed register
  input wire logic [7:0] wr_data, // write data
  input wire logic rd_en, // read strobe for the indexed register
  output logic [7:0] rd_data, // read data, valid the cycle after rd_en
  output logic rd_valid, // read answered
  input wire logic printer_mode, // printer mode bit of the port power register
  input wire logic fdc_outputs_tristate, // floppy outputs tri-state control
  input wire logic drive_density_value, // programmed density value
  output logic second_density_output, // density pin output value
  output logic second_density_oe, // density pin output enable
  input wire logic shared_pin_in, // shared pin level
  input wire logic game_port_select_req, // game port select value to drive
  output logic shared_pin_out, // shared pin output value
  output logic shared_pin_oe, // shared pin output enable
  output logic power_good_input, // captured power good level
  input wire logic extra_address_decode_req, // address decode value to drive
  input wire logic clock_run_assert, // pull clock run line low
  input wire logic mux_pin_in, // multiplexed pin level
  output logic mux_pin_out, // multiplexed pin output value
  output logic mux_pin_oe, // multiplexed pin output enable
  output logic clock_run_signal, // sampled clock run line level
  output logic enhanced_floppy_mode2, // floppy mode 2 selected
  output psr_pkg::psr_fdc_mode_t fdc_if_mode, // floppy interface mode
  output psr_pkg::psr_par_mode_t par_mode, // effective parallel port mode
  output logic parport_floppy_option_one, // floppy on parallel port, option one
  output logic parport_floppy_option_two, // floppy on parallel port, option two
  output logic [1:0] midi_enable, // serial port 2/1 MIDI divisor selected
  output logic [1:0] serial_clk_tick, // serial port 2/1 baud clock enable
  output logic epp_rev_17 // EPP revision 1.7 selected
);

  logic [7:0] pin_floppy_setup;
  logic [7:0] ext_setup;
  logic sel_pin_floppy;
  logic sel_ext;
  logic [1:0] div_tick;

  assign sel_pin_floppy = cfg_state && (config_index_register == `PSR_IDX_PIN_FLOPPY);
  assign sel_ext = cfg_state && (config_index_register == `PSR_IDX_EXT_SETUP);

  ////////////////////////////////////////////////////////////////////////////////////////////////////
  // configuration registers; reset wins over the clock enable so power-up is never frozen

  always_ff @(posedge clk)
  begin
    if (rst)
      pin_floppy_setup <= `PSR_RST_PIN_FLOPPY;
    else if (ce && wr_en && sel_pin_floppy)
      pin_floppy_setup <= wr_data & `PSR_MASK_PIN_FLOPPY;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      ext_setup <= `PSR_RST_EXT_SETUP;
    else if (ce && wr_en && sel_ext)
      ext_setup <= wr_data & `PSR_MASK_EXT_SETUP;
  end

  // outside the config state or on another index the read returns zero
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
    end
    else if (ce)
    begin
      rd_valid <= rd_en;
      if (rd_en && sel_pin_floppy)
        rd_data <= pin_floppy_setup;
      else if (rd_en && sel_ext)
        rd_data <= ext_setup;
      else
        rd_data <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////////
  // floppy controls

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      enhanced_floppy_mode2 <= 1'b0;
      fdc_if_mode <= psr_pkg::PSR_FDC_AT;
    end
    else if (ce)
    begin
      enhanced_floppy_mode2 <= pin_floppy_setup[`PSR_B_ENH_FLOPPY];
      fdc_if_mode <= psr_pkg::psr_fdc_mode_t'({pin_floppy_setup[`PSR_B_IF_IDENT],
                                               pin_floppy_setup[`PSR_B_REC_MODE]});
    end
  end

  // tri-state control overrides the force bit entirely
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      second_density_output <= 1'b1;
      second_density_oe <= 1'b0;
    end
    else if (ce)
    begin
      second_density_oe <= !fdc_outputs_tristate;
      second_density_output <= pin_floppy_setup[`PSR_B_DENS_FORCE] | drive_density_value;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////////
  // shared pins

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      shared_pin_out <= 1'b1;
      shared_pin_oe <= 1'b0;
      power_good_input <= 1'b1;
    end
    else if (ce)
    begin
      if (pin_floppy_setup[`PSR_B_SHARED_FN])
      begin
        shared_pin_out <= game_port_select_req;
        shared_pin_oe <= 1'b1;
        power_good_input <= 1'b1;
      end
      else
      begin
        shared_pin_out <= 1'b1;
        shared_pin_oe <= 1'b0;
        power_good_input <= shared_pin_in;
      end
    end
  end

  // clock run is open drain: only ever driven low, released otherwise
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mux_pin_out <= 1'b1;
      mux_pin_oe <= 1'b0;
      clock_run_signal <= 1'b1;
    end
    else if (ce)
    begin
      case (psr_pkg::psr_mux_fn_t'({pin_floppy_setup[`PSR_B_MUX_HI], pin_floppy_setup[`PSR_B_MUX_LO]}))
        psr_pkg::PSR_MUX_ADDR:
        begin
          mux_pin_out <= extra_address_decode_req;
          mux_pin_oe <= 1'b1;
          clock_run_signal <= 1'b1;
        end
        psr_pkg::PSR_MUX_CLKRUN:
        begin
          mux_pin_out <= 1'b0;
          mux_pin_oe <= clock_run_assert;
          clock_run_signal <= mux_pin_in;
        end
        default:
        begin
          mux_pin_out <= 1'b1;
          mux_pin_oe <= 1'b0;
          clock_run_signal <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////////
  // parallel and serial controls

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      par_mode <= psr_pkg::PSR_PAR_PRINTER;
      parport_floppy_option_one <= 1'b0;
      parport_floppy_option_two <= 1'b0;
      epp_rev_17 <= 1'b0;
    end
    else if (ce)
    begin
      if (printer_mode)
        par_mode <= psr_pkg::PSR_PAR_PRINTER;
      else
        par_mode <= psr_pkg::psr_par_mode_t'({1'b0, ext_setup[`PSR_B_PAR_MODE_HI:`PSR_B_PAR_MODE_LO]});
      // reserved code 11 enables neither option
      parport_floppy_option_one <= (ext_setup[`PSR_B_PPFD_HI:`PSR_B_PPFD_LO] == 2'h1);
      parport_floppy_option_two <= (ext_setup[`PSR_B_PPFD_HI:`PSR_B_PPFD_LO] == 2'h2);
      epp_rev_17 <= ext_setup[`PSR_B_EPP_TYPE];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      midi_enable <= 2'h0;
    else if (ce)
      midi_enable <= ext_setup[`PSR_B_MIDI2:`PSR_B_MIDI1];
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_ser
      psr_clkdiv u_div (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .midi(ext_setup[`PSR_B_MIDI1 + gi]),
        .tick(div_tick[gi])
      );
    end
  endgenerate

  // registered again so the top-level tick comes straight from a local flop
  always_ff @(posedge clk)
  begin
    if (rst)
      serial_clk_tick <= 2'h0;
    else if (ce)
      serial_clk_tick <= div_tick;
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_wr_pin;
    ce && wr_en && sel_pin_floppy |=> pin_floppy_setup == ($past(wr_data) & 8'hf7);
  endproperty
  a_wr_pin: assert property (p_wr_pin) else $error("pin/floppy write not stored");

  property p_wr_blocked;
    ce && !cfg_state |=> $stable(pin_floppy_setup) && $stable(ext_setup);
  endproperty
  a_wr_blocked: assert property (p_wr_blocked) else $error("register changed outside config state");

  property p_reset_vals;
    $past(rst) |-> (pin_floppy_setup == 8'h70) && (ext_setup == 8'h00);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

  property p_density_force;
    ce && !fdc_outputs_tristate && pin_floppy_setup[4] |=> second_density_oe && second_density_output;
  endproperty
  a_density_force: assert property (p_density_force) else $error("density not forced high");

  property p_density_float;
    ce && fdc_outputs_tristate |=> !second_density_oe;
  endproperty
  a_density_float: assert property (p_density_float) else $error("density output not floated");

  property p_printer;
    ce && printer_mode |=> par_mode == psr_pkg::PSR_PAR_PRINTER;
  endproperty
  a_printer: assert property (p_printer) else $error("printer mode not forced");

  property p_ecp;
    ce && !printer_mode && (ext_setup[1:0] == 2'h2) |=> par_mode == psr_pkg::PSR_PAR_ECP;
  endproperty
  a_ecp: assert property (p_ecp) else $error("ECP mode not selected");

  property p_mux_float;
    ce && !pin_floppy_setup[7] |=> !mux_pin_oe;
  endproperty
  a_mux_float: assert property (p_mux_float) else $error("multiplexed pin driven while unselected");

  property p_rsvd_read;
    ce && rd_en && sel_ext |=> rd_valid && !rd_data[7];
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("reserved bit read as one");

  property p_mode;
    ce ##1 ce |=> fdc_if_mode == psr_pkg::psr_fdc_mode_t'($past(pin_floppy_setup[6:5]));
  endproperty
  a_mode: assert property (p_mode) else $error("floppy interface mode wrong");

  c_wr_ext: cover property (ce && wr_en && sel_ext ##1 ext_setup != 8'h00);
  c_clkrun: cover property (mux_pin_oe && !mux_pin_out && (pin_floppy_setup[7:2] == 6'h21));
  c_midi_tick: cover property (midi_enable[0] && serial_clk_tick[0]);

endmodule : psr_top

// *** verif/psr_top_tb.sv ***
`timescale 1ns/10ps
module psr_top_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic cfg_state = 1'b0;
  logic [7:0] config_index_register = 8'h00;
  logic wr_en = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic rd_en = 1'b0;
  logic [7:0] rd_data;
  logic rd_valid;
  logic printer_mode = 1'b1;
  logic fdc_outputs_tristate = 1'b0;
  logic drive_density_value = 1'b0;
  logic second_density_output, second_density_oe;
  logic shared_pin_in = 1'b0;
  logic game_port_select_req = 1'b0;
  logic shared_pin_out, shared_pin_oe, power_good_input;
  logic extra_address_decode_req = 1'b0;
  logic clock_run_assert = 1'b0;
  logic mux_pin_in = 1'b1;
  logic mux_pin_out, mux_pin_oe, clock_run_signal, enhanced_floppy_mode2;
  psr_pkg::psr_fdc_mode_t fdc_if_mode;
  psr_pkg::psr_par_mode_t par_mode;
  logic parport_floppy_option_one, parport_floppy_option_two, epp_rev_17;
  logic [1:0] midi_enable;
  logic [1:0] serial_clk_tick;
  logic [7:0] sh3 = 8'h70;
  logic [7:0] sh4 = 8'h00;
  logic [7:0] exp_q[$];
  int errors = 0;
  int n_tests = 0;
  int seed_val;
  int p;
  logic [7:0] d;
  logic [7:0] ix;
  logic cs;

  always #5 clk = ~clk;

  psr_top i_psr_top (.clk(clk), .rst(rst), .ce(ce), .cfg_state(cfg_state),
    .config_index_register(config_index_register), .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en),
    .rd_data(rd_data), .rd_valid(rd_valid), .printer_mode(printer_mode),
    .fdc_outputs_tristate(fdc_outputs_tristate), .drive_density_value(drive_density_value),
    .second_density_output(second_density_output), .second_density_oe(second_density_oe),
    .shared_pin_in(shared_pin_in), .game_port_select_req(game_port_select_req),
    .shared_pin_out(shared_pin_out), .shared_pin_oe(shared_pin_oe), .power_good_input(power_good_input),
    .extra_address_decode_req(extra_address_decode_req), .clock_run_assert(clock_run_assert),
    .mux_pin_in(mux_pin_in), .mux_pin_out(mux_pin_out), .mux_pin_oe(mux_pin_oe),
    .clock_run_signal(clock_run_signal), .enhanced_floppy_mode2(enhanced_floppy_mode2),
    .fdc_if_mode(fdc_if_mode), .par_mode(par_mode), .parport_floppy_option_one(parport_floppy_option_one),
    .parport_floppy_option_two(parport_floppy_option_two), .midi_enable(midi_enable),
    .serial_clk_tick(serial_clk_tick), .epp_rev_17(epp_rev_17));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude

  task automatic cmp_rd(input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected rd_data expected %h seen %h", e, g);
    end
  endtask : cmp_rd

  task automatic cmp_pin(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_pin

  // masks model the read-as-zero reserved bits of both registers
  task automatic wr(input logic [7:0] idx, input logic [7:0] dat, input logic sel);
    @(posedge clk);
    #1;
    cfg_state = sel;
    config_index_register = idx;
    wr_data = dat;
    wr_en = 1'b1;
    @(posedge clk);
    #1;
    wr_en = 1'b0;
    cfg_state = 1'b0;
    // a write taken with the clock enable low is ignored by the block
    if (sel && ce && idx == 8'h03)
      sh3 = dat & 8'hf7;
    if (sel && ce && idx == 8'h04)
      sh4 = dat & 8'h7f;
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic sel);
    @(posedge clk);
    #1;
    cfg_state = sel;
    config_index_register = idx;
    rd_en = 1'b1;
    exp_q.push_back(!sel ? 8'h00 : idx == 8'h03 ? sh3 : idx == 8'h04 ? sh4 : 8'h00);
    @(posedge clk);
    #1;
    rd_en = 1'b0;
    cfg_state = 1'b0;
  endtask : rd

  // read answers are matched in order against the notes left by rd
  always @(negedge clk)
  begin
    if (rd_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
      begin
        errors++;
        $display("unexpected rd_valid expected 0 seen 1");
      end
      else
        cmp_rd(exp_q.pop_front(), rd_data);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_pins;
    logic [1:0] mx;
    mx = {sh3[7], sh3[2]};
    repeat (3) @(posedge clk);
    @(negedge clk);
    cmp_pin("enhanced_floppy_mode2", {7'h00, sh3[1]}, {7'h00, enhanced_floppy_mode2});
    cmp_pin("fdc_if_mode", {6'h00, sh3[6:5]}, {6'h00, fdc_if_mode});
    cmp_pin("second_density_oe", {7'h00, !fdc_outputs_tristate}, {7'h00, second_density_oe});
    if (!fdc_outputs_tristate)
      cmp_pin("second_density_output", {7'h00, sh3[4] | drive_density_value}, {7'h00, second_density_output});
    cmp_pin("shared_pin_oe", {7'h00, sh3[0]}, {7'h00, shared_pin_oe});
    cmp_pin("shared_pin_out", {7'h00, sh3[0] ? game_port_select_req : 1'b1}, {7'h00, shared_pin_out});
    cmp_pin("power_good_input", {7'h00, sh3[0] | shared_pin_in}, {7'h00, power_good_input});
    cmp_pin("mux_pin_oe", {7'h00, mx[1] && (!mx[0] || clock_run_assert)}, {7'h00, mux_pin_oe});
    if (mx[1] && mux_pin_oe === 1'b1)
      cmp_pin("mux_pin_out", {7'h00, mx[0] ? 1'b0 : extra_address_decode_req}, {7'h00, mux_pin_out});
    cmp_pin("clock_run_signal", {7'h00, mx == 2'b11 ? mux_pin_in : 1'b1}, {7'h00, clock_run_signal});
    cmp_pin("par_mode", printer_mode ? 8'h04 : {6'h00, sh4[1:0]}, {5'h00, par_mode});
    cmp_pin("parport_floppy_option_one", {7'h00, sh4[3:2] == 2'b01}, {7'h00, parport_floppy_option_one});
    cmp_pin("parport_floppy_option_two", {7'h00, sh4[3:2] == 2'b10}, {7'h00, parport_floppy_option_two});
    cmp_pin("midi_enable", {6'h00, sh4[5:4]}, {6'h00, midi_enable});
    cmp_pin("epp_rev_17", {7'h00, sh4[6]}, {7'h00, epp_rev_17});
  endtask : chk_pins

  task automatic wait_tick(input int b, output int n);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (serial_clk_tick[b] !== 1'b1 && n < 40);
    if (n >= 40)
    begin
      errors++;
      $display("unexpected serial_clk_tick expected pulse seen none");
      conclude();
    end
  endtask : wait_tick

  // the first interval may still use the count loaded before the write
  task automatic tick_period(input int b, input int e);
    int n;
    wait_tick(b, n);
    wait_tick(b, n);
    wait_tick(b, n);
    cmp_pin("serial_tick_period", e[7:0], n[7:0]);
  endtask : tick_period

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed_val = $urandom(78);
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    rd(8'h03, 1'b1);
    rd(8'h04, 1'b1);
    chk_pins();
    wr(8'h03, 8'hff, 1'b1);
    rd(8'h03, 1'b1);
    wr(8'h04, 8'hff, 1'b1);
    rd(8'h04, 1'b1);
    wr(8'h03, 8'h00, 1'b0);
    wr(8'h05, 8'h00, 1'b1);
    rd(8'h03, 1'b1);
    rd(8'h05, 1'b1);
    // let the last read answer drop before freezing, or it would be seen three times
    @(posedge clk);
    #1;
    ce = 1'b0;
    wr(8'h03, 8'h00, 1'b1);
    ce = 1'b1;
    rd(8'h03, 1'b1);
    for (int i = 0; i < 40; i++)
    begin
      @(posedge clk);
      #1;
      {printer_mode, fdc_outputs_tristate, drive_density_value, shared_pin_in} = 4'($urandom);
      {game_port_select_req, extra_address_decode_req, clock_run_assert, mux_pin_in} = 4'($urandom);
      cs = ($urandom % 4) != 0;
      ix = 8'h03 + 8'($urandom % 3);
      d = 8'($urandom);
      wr(ix, d, cs);
      rd(8'h03, 1'b1);
      rd(8'h04, cs);
      chk_pins();
    end
    wr(8'h04, 8'h10, 1'b1);
    tick_period(0, 12);
    tick_period(1, 13);
    wr(8'h04, 8'h20, 1'b1);
    tick_period(0, 13);
    tick_period(1, 12);
    repeat (4) @(posedge clk);
    cmp_pin("pending_reads", 8'h00, 8'(exp_q.size()));
    conclude();
  end
endmodule : psr_top_tb
